/* File: inc/imes_pkg.sv */
// constants, types and field layouts of the master event sequencer
package imes_pkg;
  localparam int DATA_W = 8;
  localparam int BAUD_W = 9;
  localparam int BIT_CNT_W = 4;
  // two decrements per instruction cycle of two clocks: one step per clock
  localparam logic [BAUD_W-1:0] BAUD_STEP = 9'h001;
  localparam logic [BIT_CNT_W-1:0] LAST_DATA_BIT = 4'h7;
  localparam logic [BIT_CNT_W-1:0] ACK_BIT = 4'h8;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [BAUD_W-1:0] BAUD_RESET = 9'h000;

  typedef enum logic [2:0] {
    IMES_IDLE = 3'b000,
    IMES_START_SDA = 3'b001,
    IMES_START_SCL = 3'b010,
    IMES_BIT_LOW = 3'b011,
    IMES_BIT_REL = 3'b100,
    IMES_BIT_HIGH = 3'b101,
    IMES_BIT_FALL = 3'b110,
    IMES_ACK_WAIT = 3'b111
  } imes_state_type;

  typedef enum logic [1:0] {
    IMES_MODE_TX = 2'b00,
    IMES_MODE_RX = 2'b01,
    IMES_MODE_ACK = 2'b10
  } imes_mode_type;

  typedef struct packed {
    logic ack_data_select;
    logic ack_request;
    logic receive_request;
    logic start_request;
  } imes_ctrl_type;

  typedef struct packed {
    logic ack_status_flag;
    logic transmitting_flag;
    logic write_collision_flag;
    logic rx_overflow_flag;
    logic stop_seen;
    logic start_seen;
    logic rx_buffer_full;
    logic tx_buffer_full;
  } imes_status_type;

  localparam imes_ctrl_type CTRL_RESET = 4'h0;
  localparam imes_status_type STATUS_RESET = 8'h00;
endpackage

/* File: verilog/imes_baud_gen.sv */
// down-counting baud generator: one timeout pulse per load
`timescale 1ns/1ps
module imes_baud_gen (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic load,
  input wire logic [imes_pkg::BAUD_W-1:0] reload_value,
  // event
  output logic timeout
);
  logic [imes_pkg::BAUD_W-1:0] count;
  logic running;
  logic [imes_pkg::BAUD_W-1:0] next_count;
  logic next_running;
  logic next_timeout;

  always_comb
  begin
    next_count = count;
    next_running = running;
    next_timeout = 1'b0;
    if (load)
    begin
      next_count = reload_value;
      next_running = 1'b1;
    end
    else if (running)
    begin
      // a zero reload is unsupported; it behaves as one
      if (count <= imes_pkg::BAUD_STEP)
      begin
        next_count = imes_pkg::BAUD_RESET;
        next_running = 1'b0;
        next_timeout = 1'b1;
      end
      else
      begin
        next_count = count - imes_pkg::BAUD_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= imes_pkg::BAUD_RESET;
      running <= 1'b0;
      timeout <= 1'b0;
    end
    else
    begin
      count <= next_count;
      running <= next_running;
      timeout <= next_timeout;
    end
  end
endmodule // imes_baud_gen

/* File: verilog/imes_bus_monitor.sv */
// start and stop condition detector on the synchronised bus lines
`timescale 1ns/1ps
module imes_bus_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // synchronised lines
  input wire logic scl_sync,
  input wire logic sda_sync,
  // events
  output logic start_det,
  output logic stop_det
);
  logic sda_prev;
  logic next_start_det;
  logic next_stop_det;

  always_comb
  begin
    // sda moving while scl high marks a condition
    next_start_det = scl_sync && sda_prev && !sda_sync;
    next_stop_det = scl_sync && !sda_prev && sda_sync;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_prev <= 1'b1;
      start_det <= 1'b0;
      stop_det <= 1'b0;
    end
    else
    begin
      sda_prev <= sda_sync;
      start_det <= next_start_det;
      stop_det <= next_stop_det;
    end
  end
endmodule // imes_bus_monitor

/* File: verilog/imes_sequencer.sv */
// master event sequencer: start, byte transmit, byte receive, acknowledge
`timescale 1ns/1ps
module imes_sequencer (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control writes
  input wire logic ctrl_write,
  input wire imes_pkg::imes_ctrl_type ctrl_wdata,
  input wire logic [imes_pkg::BAUD_W-1:0] baud_reload_value,
  // transmit buffer write
  input wire logic tx_write,
  input wire logic [imes_pkg::DATA_W-1:0] tx_data,
  // status side effects
  input wire logic rx_read,
  input wire logic wcol_clear,
  input wire logic ov_clear,
  // register views
  output imes_pkg::imes_ctrl_type bus_control_reg,
  output imes_pkg::imes_status_type bus_status_reg,
  output logic [imes_pkg::DATA_W-1:0] receive_buffer,
  output logic master_event_irq,
  // clock line, open drain
  input wire logic scl_level,
  output logic scl_drive,
  output logic scl_oe_n,
  // data line, open drain
  input wire logic sda_level,
  output logic sda_drive,
  output logic sda_oe_n
);
  // synchronisers
  logic scl_meta;
  logic scl_sync;
  logic sda_meta;
  logic sda_sync;

  // sequencer state
  imes_pkg::imes_state_type state;
  imes_pkg::imes_mode_type mode;
  logic [imes_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [imes_pkg::DATA_W-1:0] shift;
  logic sampled_sda;
  logic baud_load;

  // next values
  imes_pkg::imes_state_type next_state;
  imes_pkg::imes_mode_type next_mode;
  logic [imes_pkg::BIT_CNT_W-1:0] next_bit_cnt;
  logic [imes_pkg::DATA_W-1:0] next_shift;
  logic next_sampled_sda;
  logic next_baud_load;
  imes_pkg::imes_ctrl_type next_ctrl;
  imes_pkg::imes_status_type next_status;
  logic [imes_pkg::DATA_W-1:0] next_rx_buf;
  logic next_irq;
  logic next_scl_oe_n;
  logic next_sda_oe_n;

  // helper wires
  logic baud_timeout;
  logic start_det;
  logic stop_det;
  logic busy;

  // open-drain level for one data bit: release for a one
  function automatic logic bit_oe_n(input logic value);
    bit_oe_n = value;
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_level;
      scl_sync <= scl_meta;
      sda_meta <= sda_level;
      sda_sync <= sda_meta;
    end
  end

  imes_baud_gen u_baud (
    .clk(clk),
    .reset_n(reset_n),
    .load(baud_load),
    .reload_value(baud_reload_value),
    .timeout(baud_timeout)
  );

  imes_bus_monitor u_monitor (
    .clk(clk),
    .reset_n(reset_n),
    .scl_sync(scl_sync),
    .sda_sync(sda_sync),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  assign busy = (state != imes_pkg::IMES_IDLE);

  always_comb
  begin
    next_state = state;
    next_mode = mode;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_sampled_sda = sampled_sda;
    next_baud_load = 1'b0;
    next_ctrl = bus_control_reg;
    next_status = bus_status_reg;
    next_rx_buf = receive_buffer;
    next_irq = 1'b0;
    next_scl_oe_n = scl_oe_n;
    next_sda_oe_n = sda_oe_n;

    // software clears go first so that hardware sets below win
    if (wcol_clear)
    begin
      next_status.write_collision_flag = 1'b0;
    end
    if (ov_clear)
    begin
      next_status.rx_overflow_flag = 1'b0;
    end
    if (rx_read)
    begin
      next_status.rx_buffer_full = 1'b0;
    end
    if (start_det)
    begin
      next_status.start_seen = 1'b1;
      next_status.stop_seen = 1'b0;
    end
    if (stop_det)
    begin
      next_status.stop_seen = 1'b1;
      next_status.start_seen = 1'b0;
    end

    case (state)
      imes_pkg::IMES_IDLE:
      begin
        // ack_data_select is plain configuration, writable only while idle
        if (ctrl_write)
        begin
          next_ctrl.ack_data_select = ctrl_wdata.ack_data_select;
        end
        if (ctrl_write && ctrl_wdata.start_request)
        begin
          next_ctrl.start_request = 1'b1;
          next_scl_oe_n = 1'b1;
          next_sda_oe_n = 1'b1;
          next_baud_load = 1'b1;
          next_state = imes_pkg::IMES_START_SDA;
        end
        else if (ctrl_write && ctrl_wdata.receive_request)
        begin
          next_ctrl.receive_request = 1'b1;
          next_mode = imes_pkg::IMES_MODE_RX;
          next_bit_cnt = '0;
          next_sda_oe_n = 1'b1;
          next_baud_load = 1'b1;
          next_state = imes_pkg::IMES_BIT_LOW;
        end
        else if (ctrl_write && ctrl_wdata.ack_request)
        begin
          next_ctrl.ack_request = 1'b1;
          next_mode = imes_pkg::IMES_MODE_ACK;
          next_bit_cnt = imes_pkg::ACK_BIT;
          next_state = imes_pkg::IMES_ACK_WAIT;
        end
        else if (tx_write && !ctrl_write)
        begin
          // bytes are sent verbatim, no content check
          next_shift = tx_data;
          next_status.tx_buffer_full = 1'b1;
          next_status.transmitting_flag = 1'b1;
          next_mode = imes_pkg::IMES_MODE_TX;
          next_bit_cnt = '0;
          next_sda_oe_n = bit_oe_n(tx_data[imes_pkg::DATA_W-1]);
          next_baud_load = 1'b1;
          next_state = imes_pkg::IMES_BIT_LOW;
        end
        // a transmit write beside any control write collides
        if (tx_write && ctrl_write)
        begin
          next_status.write_collision_flag = 1'b1;
        end
      end
      imes_pkg::IMES_START_SDA:
      begin
        if (baud_timeout)
        begin
          next_sda_oe_n = 1'b0;
          next_baud_load = 1'b1;
          next_state = imes_pkg::IMES_START_SCL;
        end
      end
      imes_pkg::IMES_START_SCL:
      begin
        if (baud_timeout)
        begin
          // both lines stay low until the next event
          next_scl_oe_n = 1'b0;
          next_ctrl.start_request = 1'b0;
          next_irq = 1'b1;
          next_state = imes_pkg::IMES_IDLE;
        end
      end
      imes_pkg::IMES_ACK_WAIT:
      begin
        if (!scl_sync)
        begin
          next_sda_oe_n = bus_control_reg.ack_data_select;
          next_baud_load = 1'b1;
          next_state = imes_pkg::IMES_BIT_LOW;
        end
      end
      imes_pkg::IMES_BIT_LOW:
      begin
        if (baud_timeout)
        begin
          next_scl_oe_n = 1'b1;
          next_state = imes_pkg::IMES_BIT_REL;
        end
      end
      imes_pkg::IMES_BIT_REL:
      begin
        // a stretching slave holds us here, baud suspended
        if (scl_sync)
        begin
          next_baud_load = 1'b1;
          next_state = imes_pkg::IMES_BIT_HIGH;
        end
      end
      imes_pkg::IMES_BIT_HIGH:
      begin
        if (baud_timeout)
        begin
          // sample just before our own falling edge
          next_sampled_sda = sda_sync;
          if (mode == imes_pkg::IMES_MODE_RX)
          begin
            next_shift = {shift[imes_pkg::DATA_W-2:0], sda_sync};
          end
          next_scl_oe_n = 1'b0;
          next_state = imes_pkg::IMES_BIT_FALL;
        end
      end
      imes_pkg::IMES_BIT_FALL:
      begin
        // data moves only once scl is seen low
        if (!scl_sync)
        begin
          case (mode)
            imes_pkg::IMES_MODE_TX:
            begin
              if (bit_cnt == imes_pkg::ACK_BIT)
              begin
                next_status.ack_status_flag = sampled_sda;
                next_status.transmitting_flag = 1'b0;
                next_irq = 1'b1;
                next_state = imes_pkg::IMES_IDLE;
              end
              else if (bit_cnt == imes_pkg::LAST_DATA_BIT)
              begin
                next_status.tx_buffer_full = 1'b0;
                next_sda_oe_n = 1'b1;
                next_bit_cnt = imes_pkg::ACK_BIT;
                next_baud_load = 1'b1;
                next_state = imes_pkg::IMES_BIT_LOW;
              end
              else
              begin
                next_shift = {shift[imes_pkg::DATA_W-2:0], 1'b0};
                next_sda_oe_n = bit_oe_n(shift[imes_pkg::DATA_W-2]);
                next_bit_cnt = bit_cnt + 4'h1;
                next_baud_load = 1'b1;
                next_state = imes_pkg::IMES_BIT_LOW;
              end
            end
            imes_pkg::IMES_MODE_RX:
            begin
              if (bit_cnt == imes_pkg::LAST_DATA_BIT)
              begin
                next_ctrl.receive_request = 1'b0;
                // a full buffer keeps its byte; the new one is dropped
                if (bus_status_reg.rx_buffer_full && !rx_read)
                begin
                  next_status.rx_overflow_flag = 1'b1;
                end
                else
                begin
                  next_rx_buf = shift;
                  next_status.rx_buffer_full = 1'b1;
                end
                next_irq = 1'b1;
                next_state = imes_pkg::IMES_IDLE;
              end
              else
              begin
                next_bit_cnt = bit_cnt + 4'h1;
                next_baud_load = 1'b1;
                next_state = imes_pkg::IMES_BIT_LOW;
              end
            end
            imes_pkg::IMES_MODE_ACK:
            begin
              next_sda_oe_n = 1'b1;
              next_ctrl.ack_request = 1'b0;
              next_irq = 1'b1;
              next_state = imes_pkg::IMES_IDLE;
            end
            default:
            begin
              next_state = imes_pkg::IMES_IDLE;
            end
          endcase
        end
      end
      default:
      begin
        next_state = imes_pkg::IMES_IDLE;
      end
    endcase

    // while busy, request writes fall away and transmit writes collide
    if (busy && tx_write)
    begin
      next_status.write_collision_flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= imes_pkg::IMES_IDLE;
      mode <= imes_pkg::IMES_MODE_TX;
      bit_cnt <= '0;
      shift <= imes_pkg::DATA_RESET;
      sampled_sda <= 1'b1;
      baud_load <= 1'b0;
      bus_control_reg <= imes_pkg::CTRL_RESET;
      bus_status_reg <= imes_pkg::STATUS_RESET;
      receive_buffer <= imes_pkg::DATA_RESET;
      master_event_irq <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
    end
    else
    begin
      state <= next_state;
      mode <= next_mode;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      sampled_sda <= next_sampled_sda;
      baud_load <= next_baud_load;
      bus_control_reg <= next_ctrl;
      bus_status_reg <= next_status;
      receive_buffer <= next_rx_buf;
      master_event_irq <= next_irq;
      scl_oe_n <= next_scl_oe_n;
      sda_oe_n <= next_sda_oe_n;
      // open drain: only ever drives low
      scl_drive <= 1'b0;
      sda_drive <= 1'b0;
    end
  end
endmodule // imes_sequencer

/* File: bench/imes_chk.sv */
// port assertions of the master event sequencer
`timescale 1ns/1ps
module imes_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // software side
  input wire logic ctrl_write,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic wcol_clear,
  // register views
  input wire imes_pkg::imes_ctrl_type bus_control_reg,
  input wire imes_pkg::imes_status_type bus_status_reg,
  input wire logic master_event_irq,
  // line enables
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic busy;
  assign busy = bus_control_reg.start_request || bus_control_reg.receive_request ||
    bus_control_reg.ack_request || bus_status_reg.transmitting_flag;

  a_start_done: assert property ($fell(bus_control_reg.start_request) |->
    !scl_oe_n && !sda_oe_n && master_event_irq) else $error("start end wrong");
  a_scl_held: assert property (!scl_oe_n && !busy && !ctrl_write && !tx_write
    |=> !scl_oe_n) else $error("idle scl let go");
  a_sda_step: assert property (bus_status_reg.transmitting_flag && $changed(sda_oe_n)
    |-> !scl_oe_n && !$past(scl_oe_n)) else $error("sda moved with scl high");
  a_tx_take: assert property (tx_write && !ctrl_write && !busy |=>
    bus_status_reg.tx_buffer_full && bus_status_reg.transmitting_flag) else $error("tx not taken");
  a_wcol_set: assert property (tx_write && busy |=>
    bus_status_reg.write_collision_flag) else $error("collision missed");
  a_wcol_keep: assert property (bus_status_reg.write_collision_flag && !wcol_clear |=>
    bus_status_reg.write_collision_flag) else $error("collision lost");
  a_ctrl_ignore: assert property (busy && ctrl_write |=>
    (bus_control_reg & ~$past(bus_control_reg)) == '0) else $error("request queued");
  a_rbf_clear: assert property (rx_read && !bus_control_reg.receive_request |=>
    !bus_status_reg.rx_buffer_full) else $error("full flag kept");
  a_rx_done: assert property ($fell(bus_control_reg.receive_request) |->
    bus_status_reg.rx_buffer_full && master_event_irq) else $error("rx end wrong");
  a_rx_overrun: assert property ($fell(bus_control_reg.receive_request) &&
    $past(bus_status_reg.rx_buffer_full) && !$past(rx_read) |->
    bus_status_reg.rx_overflow_flag) else $error("overflow missed");
  a_tx_done: assert property ($fell(bus_status_reg.transmitting_flag) |->
    master_event_irq && !bus_status_reg.tx_buffer_full && !scl_oe_n) else $error("tx end wrong");
  a_ack_done: assert property ($fell(bus_control_reg.ack_request) |->
    master_event_irq && !scl_oe_n && sda_oe_n) else $error("ack end wrong");
endmodule // imes_chk

bind imes_sequencer imes_chk u_chk (.clk, .reset_n, .ctrl_write, .tx_write, .rx_read,
  .wcol_clear, .bus_control_reg, .bus_status_reg, .master_event_irq, .scl_oe_n, .sda_oe_n);

/* File: bench/imes_slave.sv */
// behavioural serial bus slave facing the sequencer
`timescale 1ns/1ps
module imes_slave (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // behaviour
  input wire logic read_dir,
  input wire logic ack_en,
  input wire logic stretch,
  input wire logic [7:0] tx_byte,
  // pull-downs and observations
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] got_byte,
  output logic got_ack
);
  int cnt = 0;
  int pos;
  logic hold = 1'b0;
  assign scl_low = hold;
  // bit position in the nine-bit frame, counted from the start's own fall
  assign pos = cnt % 9;
  assign sda_low = read_dir ? (pos >= 0 && pos < 8 && !tx_byte[7 - pos])
    : (pos == 8 && ack_en);
  always @(negedge sda)
    if (scl)
      cnt = -1;
  always @(negedge scl)
  begin
    cnt = cnt + 1;
    if (stretch)
    begin
      hold = 1'b1;
      #200 hold = 1'b0;
    end
  end
  always @(posedge scl)
    if (pos >= 0 && pos < 8)
      got_byte = {got_byte[6:0], sda};
    else if (pos == 8)
      got_ack = sda;
endmodule // imes_slave

/* File: bench/tb_top.sv */
// self-checking bench of the master event sequencer
`timescale 1ns/1ps
module tb_top;
  // reload for an 80 ns scl period: each half is reload plus five clocks
  localparam logic [8:0] BAUD_RELOAD = 9'h005;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ctrl_write = 1'b0;
  imes_pkg::imes_ctrl_type ctrl_wdata = imes_pkg::CTRL_RESET;
  logic tx_write = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic rx_read = 1'b0;
  logic wcol_clear = 1'b0;
  logic ov_clear = 1'b0;
  logic tb_sda_low = 1'b0;
  logic read_dir = 1'b0;
  logic ack_en = 1'b1;
  logic stretch = 1'b0;
  logic [7:0] s_byte = 8'h00;
  imes_pkg::imes_ctrl_type ctl;
  imes_pkg::imes_status_type st;
  logic [7:0] rbuf;
  logic [7:0] got;
  logic irq, scl_oe_n, sda_oe_n, s_scl_low, s_sda_low, got_ack, scl, sda;
  logic scl_drive, sda_drive;
  int error_cnt = 0;
  int num_checks = 0;
  time t0;

  always #2 clk = ~clk;
  // both lines pulled up
  assign scl = (scl_oe_n || scl_drive) && !s_scl_low;
  assign sda = (sda_oe_n || sda_drive) && !s_sda_low && !tb_sda_low;

  imes_sequencer dut (.clk(clk), .reset_n(reset_n), .ctrl_write(ctrl_write),
    .ctrl_wdata(ctrl_wdata), .baud_reload_value(BAUD_RELOAD), .tx_write(tx_write),
    .tx_data(tx_data), .rx_read(rx_read), .wcol_clear(wcol_clear), .ov_clear(ov_clear),
    .bus_control_reg(ctl), .bus_status_reg(st), .receive_buffer(rbuf),
    .master_event_irq(irq), .scl_level(scl), .scl_drive(scl_drive), .scl_oe_n(scl_oe_n),
    .sda_level(sda), .sda_drive(sda_drive), .sda_oe_n(sda_oe_n));
  imes_slave slave (.scl(scl), .sda(sda), .read_dir(read_dir), .ack_en(ack_en),
    .stretch(stretch), .tx_byte(s_byte), .scl_low(s_scl_low), .sda_low(s_sda_low),
    .got_byte(got), .got_ack(got_ack));

  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic wr_ctrl(input logic [3:0] v);
    ctrl_wdata = v;
    pulse(ctrl_write);
  endtask
  // irq stands one cycle, so it is polled at every falling edge
  task automatic wait_irq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++)
      @(negedge clk);
    chk_bit(irq, 1'b1);
  endtask
  task automatic send(input logic [7:0] b, input logic ack);
    ack_en = ack;
    tx_data = b;
    pulse(tx_write);
    chk_bit(st.tx_buffer_full, 1'b1);
    chk_bit(st.transmitting_flag, 1'b1);
    wait_irq();
    chk_byte(got, b);
    chk_bit(st.ack_status_flag, !ack);
    chk_bit(st.transmitting_flag, 1'b0);
    chk_bit(st.tx_buffer_full, 1'b0);
  endtask
  task automatic recv(input logic [7:0] b);
    s_byte = b;
    chk_byte({4'h0, ctl}, 8'h00);
    wr_ctrl(4'h2);
    chk_bit(ctl.receive_request, 1'b1);
    wait_irq();
    chk_bit(ctl.receive_request, 1'b0);
    chk_bit(st.rx_buffer_full, 1'b1);
  endtask
  task automatic ack_seq(input logic dt);
    wr_ctrl({dt, 3'b100});
    wait_irq();
    chk_bit(got_ack, dt);
    chk_bit(ctl.ack_request, 1'b0);
    chk_bit(scl_oe_n, 1'b0);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    cyc(6);
    reset_n = 1'b1;
    cyc(4);
    chk_byte(st, imes_pkg::STATUS_RESET);
    chk_bit(scl_oe_n & sda_oe_n, 1'b1);
    tb_sda_low = 1'b1;
    cyc(10);
    chk_bit(st.start_seen, 1'b1);
    tb_sda_low = 1'b0;
    cyc(10);
    chk_bit(st.stop_seen, 1'b1);
    wr_ctrl(4'h1);
    t0 = $time;
    tx_data = 8'hee;
    pulse(tx_write);
    wr_ctrl(4'h2);
    chk_bit(ctl.receive_request, 1'b0);
    chk_bit(st.write_collision_flag, 1'b1);
    chk_bit(st.tx_buffer_full, 1'b0);
    wait_irq();
    chk_byte(8'(($time - t0) / 64'h4), 8'(BAUD_RELOAD + BAUD_RELOAD + 9'h004));
    chk_bit(ctl.start_request, 1'b0);
    chk_bit(st.start_seen & ~st.stop_seen, 1'b1);
    cyc(20);
    chk_bit(scl_oe_n | sda_oe_n, 1'b0);
    chk_bit(st.write_collision_flag, 1'b1);
    pulse(wcol_clear);
    chk_bit(st.write_collision_flag, 1'b0);
    stretch = 1'b1;
    send(8'hf0, 1'b1);
    stretch = 1'b0;
    send(8'h5a, 1'b0);
    read_dir = 1'b1;
    recv(8'ha5);
    chk_byte(rbuf, 8'ha5);
    ack_seq(1'b0);
    recv(8'h3c);
    chk_bit(st.rx_overflow_flag, 1'b1);
    chk_byte(rbuf, 8'ha5);
    ack_seq(1'b0);
    pulse(rx_read);
    chk_bit(st.rx_buffer_full, 1'b0);
    recv(8'hc3);
    chk_byte(rbuf, 8'hc3);
    pulse(ov_clear);
    chk_bit(st.rx_overflow_flag, 1'b0);
    ack_seq(1'b1);
    close_out();
  end

  initial
  begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule // tb_top
